/* File: rtl/dsm_output_mapper.sv */
// drive status generation, terminal mapping and AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module dsm_output_mapper #(
  parameter int FREQ_W = 16,
  parameter int VOLT_W = 16
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // drive control state
  input  wire logic [FREQ_W-1:0] output_freq,
  input  wire logic [FREQ_W-1:0] reference_freq,
  input  wire logic [VOLT_W-1:0] dc_bus_voltage,
  input  wire logic              dc_braking,
  input  wire logic              uv_trip_hold,
  // externally generated status signals
  input  wire logic              output_limiting,
  input  wire logic              power_dip_restart,
  input  wire logic              motor_overload_warning,
  input  wire logic              auto_reset_active,
  input  wire logic              service_lifetime_alarm,
  input  wire logic              overload_prevention,
  input  wire logic              overcurrent_detect,
  input  wire logic              overcurrent_detect_second,
  input  wire logic              low_current_detect,
  input  wire logic              loop_regulator_active,
  input  wire logic              regulator_lowflow_stop,
  input  wire logic              second_motor_selected,
  input  wire logic              thermistor_overheat,
  input  wire logic              brake_command,
  input  wire logic              current_input_wire_break,
  input  wire logic              maintenance_timer,
  input  wire logic              any_alarm,
  // output terminals
  output logic                   transistor_terminal,
  output logic                   relay_coil,
  output logic                   relay_no_closed,
  output logic                   relay_nc_closed,
  // interrupt
  output logic                   irq
);
  import dsm_pkg::*;

  if (FREQ_W < 4 || FREQ_W > 32 || VOLT_W < 4 || VOLT_W > 32) begin : g_width_check
    $error("dsm_output_mapper: FREQ_W and VOLT_W must lie in 4..32");
  end

  // registers
  logic [SEL_W-1:0]      tsel_reg;
  logic [SEL_W-1:0]      rsel_reg;
  logic [FREQ_W-1:0]     arr_hyst_reg;
  logic [FREQ_W-1:0]     det_lvl_reg;
  logic [FREQ_W-1:0]     det_hyst_reg;
  logic [FREQ_W-1:0]     start_freq_reg;
  logic [FREQ_W-1:0]     stop_freq_reg;
  logic [VOLT_W-1:0]     uv_level_reg;
  logic [NUM_EVENTS-1:0] int_status_reg;
  logic [NUM_EVENTS-1:0] int_enable_reg;
  // bus pipeline
  logic                  ap_wr_reg;
  logic [7:0]            ap_addr_reg;
  logic [31:0]           rdata_next;
  // core status
  logic                  running_reg;
  logic                  running2_reg;
  logic                  arrival_reg;
  logic                  level_reg;
  logic                  uv_cmp_reg;
  logic                  undervolt;
  logic [FREQ_W-1:0]     freq_diff;
  logic [FREQ_W-1:0]     level_low;
  logic [NUM_CODES-1:0]  status_vec;
  logic [NUM_CODES-1:0]  defined_mask;
  logic [NUM_EVENTS-1:0] cur_status;
  logic [NUM_EVENTS-1:0] prev_status_reg;
  logic [NUM_EVENTS-1:0] events;
  logic                  bus_take;
  logic                  wr_clear;

  // zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign bus_take  = hsel && hready && htrans[1];

  // address phase capture; the data phase of a write follows one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg   <= 1'b0;
      ap_addr_reg <= 8'h00;
    end else begin
      ap_wr_reg   <= bus_take && hwrite;
      ap_addr_reg <= bus_take ? {haddr[7:2], 2'b00} : ap_addr_reg;
    end
  end

  // read mux; unmapped and write-only offsets read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case ({haddr[7:2], 2'b00})
      OFS_TSEL:       rdata_next[SEL_W-1:0] = tsel_reg;
      OFS_RSEL:       rdata_next[SEL_W-1:0] = rsel_reg;
      OFS_ARR_HYST:   rdata_next[FREQ_W-1:0] = arr_hyst_reg;
      OFS_DET_LVL:    rdata_next[FREQ_W-1:0] = det_lvl_reg;
      OFS_DET_HYST:   rdata_next[FREQ_W-1:0] = det_hyst_reg;
      OFS_START_FREQ: rdata_next[FREQ_W-1:0] = start_freq_reg;
      OFS_STOP_FREQ:  rdata_next[FREQ_W-1:0] = stop_freq_reg;
      OFS_UV_LEVEL:   rdata_next[VOLT_W-1:0] = uv_level_reg;
      OFS_STATUS:     rdata_next[NUM_EVENTS-1:0] = cur_status;
      OFS_INT_STATUS: rdata_next[NUM_EVENTS-1:0] = int_status_reg;
      OFS_INT_ENABLE: rdata_next[NUM_EVENTS-1:0] = int_enable_reg;
      default:        rdata_next = 32'h0000_0000;
    endcase
  end

  // read data is sampled at the address phase so it stands from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_take && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

  // configuration writes; reset keeps both terminals in normal polarity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tsel_reg       <= RST_TSEL;
      rsel_reg       <= RST_RSEL;
      arr_hyst_reg   <= FREQ_W'(RST_FREQ);
      det_lvl_reg    <= FREQ_W'(RST_FREQ);
      det_hyst_reg   <= FREQ_W'(RST_FREQ);
      start_freq_reg <= FREQ_W'(RST_FREQ);
      stop_freq_reg  <= FREQ_W'(RST_FREQ);
      uv_level_reg   <= VOLT_W'(RST_FREQ);
      int_enable_reg <= RST_INT_ENABLE;
    end else if (ap_wr_reg) begin
      case (ap_addr_reg)
        OFS_TSEL:       tsel_reg <= hwdata[SEL_W-1:0];
        OFS_RSEL:       rsel_reg <= hwdata[SEL_W-1:0];
        OFS_ARR_HYST:   arr_hyst_reg <= hwdata[FREQ_W-1:0];
        OFS_DET_LVL:    det_lvl_reg <= hwdata[FREQ_W-1:0];
        OFS_DET_HYST:   det_hyst_reg <= hwdata[FREQ_W-1:0];
        OFS_START_FREQ: start_freq_reg <= hwdata[FREQ_W-1:0];
        OFS_STOP_FREQ:  stop_freq_reg <= hwdata[FREQ_W-1:0];
        OFS_UV_LEVEL:   uv_level_reg <= hwdata[VOLT_W-1:0];
        OFS_INT_ENABLE: int_enable_reg <= hwdata[NUM_EVENTS-1:0];
        default:        ;
      endcase
    end
  end

  // running: on above start, off below stop, forced off while braking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      running_reg  <= 1'b0;
      running2_reg <= 1'b0;
    end else begin
      if (dc_braking) begin
        running_reg <= 1'b0;
      end else if (output_freq > start_freq_reg) begin
        running_reg <= 1'b1;
      end else if (output_freq < stop_freq_reg) begin
        running_reg <= 1'b0;
      end
      // the braking variant stays on through dc braking
      if (dc_braking) begin
        running2_reg <= running2_reg | running_reg;
      end else if (output_freq > start_freq_reg) begin
        running2_reg <= 1'b1;
      end else if (output_freq < stop_freq_reg) begin
        running2_reg <= 1'b0;
      end
    end
  end

  // absolute difference and saturated lower threshold avoid wrap-around
  assign freq_diff = (output_freq >= reference_freq) ? (output_freq - reference_freq)
                                                     : (reference_freq - output_freq);
  assign level_low = (det_lvl_reg > det_hyst_reg) ? (det_lvl_reg - det_hyst_reg)
                                                  : '0;

  // arrival and level detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arrival_reg <= 1'b0;
      level_reg   <= 1'b0;
    end else begin
      arrival_reg <= (freq_diff <= arr_hyst_reg);
      if (output_freq > det_lvl_reg) begin
        level_reg <= 1'b1;
      end else if (output_freq < level_low) begin
        level_reg <= 1'b0;
      end
    end
  end

  // undervoltage compare holds between the two strict crossings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uv_cmp_reg <= 1'b0;
    end else if (dc_bus_voltage < uv_level_reg) begin
      uv_cmp_reg <= 1'b1;
    end else if (dc_bus_voltage > uv_level_reg) begin
      uv_cmp_reg <= 1'b0;
    end
  end
  assign undervolt = uv_cmp_reg | uv_trip_hold;

  // status vector indexed by selection code
  always_comb begin
    status_vec = '0;
    status_vec[CODE_RUN]         = running_reg;
    status_vec[CODE_ARRIVAL]     = arrival_reg;
    status_vec[CODE_LEVEL]       = level_reg;
    status_vec[CODE_UNDERVOLT]   = undervolt;
    status_vec[CODE_OUT_LIMIT]   = output_limiting;
    status_vec[CODE_DIP_RESTART] = power_dip_restart;
    status_vec[CODE_OL_WARN]     = motor_overload_warning;
    status_vec[CODE_AUTO_RESET]  = auto_reset_active;
    status_vec[CODE_LIFETIME]    = service_lifetime_alarm;
    status_vec[CODE_RUN_BRAKE]   = running2_reg;
    status_vec[CODE_OL_PREVENT]  = overload_prevention;
    status_vec[CODE_CUR_DET]     = overcurrent_detect;
    status_vec[CODE_CUR_DET2]    = overcurrent_detect_second;
    status_vec[CODE_LOW_CUR]     = low_current_detect;
    status_vec[CODE_REG_ACTIVE]  = loop_regulator_active;
    status_vec[CODE_REG_STOP]    = regulator_lowflow_stop;
    status_vec[CODE_MOTOR2]      = second_motor_selected;
    status_vec[CODE_THERMISTOR]  = thermistor_overheat;
    status_vec[CODE_BRAKE]       = brake_command;
    status_vec[CODE_WIRE_BREAK]  = current_input_wire_break;
    status_vec[CODE_MAINT]       = maintenance_timer;
    status_vec[CODE_ARR_LEVEL]   = arrival_reg & level_reg;
    status_vec[CODE_ALARM]       = any_alarm;
  end

  // which codes carry a signal; gaps in the table give an off terminal
  always_comb begin
    defined_mask = '0;
    defined_mask[CODE_RUN]         = 1'b1;
    defined_mask[CODE_ARRIVAL]     = 1'b1;
    defined_mask[CODE_LEVEL]       = 1'b1;
    defined_mask[CODE_UNDERVOLT]   = 1'b1;
    defined_mask[CODE_OUT_LIMIT]   = 1'b1;
    defined_mask[CODE_DIP_RESTART] = 1'b1;
    defined_mask[CODE_OL_WARN]     = 1'b1;
    defined_mask[CODE_AUTO_RESET]  = 1'b1;
    defined_mask[CODE_LIFETIME]    = 1'b1;
    defined_mask[CODE_RUN_BRAKE]   = 1'b1;
    defined_mask[CODE_OL_PREVENT]  = 1'b1;
    defined_mask[CODE_CUR_DET]     = 1'b1;
    defined_mask[CODE_CUR_DET2]    = 1'b1;
    defined_mask[CODE_LOW_CUR]     = 1'b1;
    defined_mask[CODE_REG_ACTIVE]  = 1'b1;
    defined_mask[CODE_REG_STOP]    = 1'b1;
    defined_mask[CODE_MOTOR2]      = 1'b1;
    defined_mask[CODE_THERMISTOR]  = 1'b1;
    defined_mask[CODE_BRAKE]       = 1'b1;
    defined_mask[CODE_WIRE_BREAK]  = 1'b1;
    defined_mask[CODE_MAINT]       = 1'b1;
    defined_mask[CODE_ARR_LEVEL]   = 1'b1;
    defined_mask[CODE_ALARM]       = 1'b1;
  end

  // two independent terminals, each with its own code
  dsm_term_drive u_transistor (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .sel_code     (tsel_reg),
    .status_vec   (status_vec),
    .defined_mask (defined_mask),
    .term_out     (transistor_terminal)
  );

  dsm_term_drive u_relay (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .sel_code     (rsel_reg),
    .status_vec   (status_vec),
    .defined_mask (defined_mask),
    .term_out     (relay_coil)
  );

  // changeover contacts follow the coil flop
  assign relay_no_closed = relay_coil;
  assign relay_nc_closed = ~relay_coil;

  // events are rising edges of status; set beats a simultaneous clear
  assign cur_status = {relay_coil, transistor_terminal, undervolt, level_reg,
                       arrival_reg, running_reg};
  assign events     = cur_status & ~prev_status_reg;
  assign wr_clear   = ap_wr_reg && (ap_addr_reg == OFS_INT_CLEAR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_status_reg <= '0;
      int_status_reg  <= '0;
    end else begin
      prev_status_reg <= cur_status;
      int_status_reg  <= (int_status_reg & ~(wr_clear ? hwdata[NUM_EVENTS-1:0] : '0))
                         | events;
    end
  end

  assign irq = |(int_status_reg & int_enable_reg);

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_run_braking: assert property (dc_braking |=> !running_reg)
    else $error("running asserted during dc braking");
  a_run_start: assert property (!dc_braking && output_freq > start_freq_reg
                                |=> running_reg)
    else $error("running missing above start frequency");
  a_arrival_zone: assert property (hresetn && (freq_diff <= arr_hyst_reg) |=> arrival_reg)
    else $error("arrival missing inside hysteresis zone");
  a_level_hold: assert property (level_reg && !(output_freq < level_low)
                                 |=> level_reg)
    else $error("level detect dropped inside hysteresis band");
  a_uv_trip: assert property (uv_trip_hold |-> undervolt)
    else $error("undervoltage not held during trip");
  a_uv_clear: assert property (!uv_trip_hold && dc_bus_voltage > uv_level_reg
                               |=> !undervolt || uv_trip_hold)
    else $error("undervoltage stuck above threshold");
  a_map_normal: assert property (tsel_reg == 11'h000 |=>
                                 transistor_terminal == $past(running_reg))
    else $error("transistor terminal does not follow running");
  a_map_stopped: assert property (tsel_reg == POL_OFFSET |=>
                                  transistor_terminal == !$past(running_reg))
    else $error("inverted running is not a stopped indication");
  a_relay_alarm: assert property (rsel_reg == 11'h063 |=>
                                  relay_no_closed == $past(any_alarm))
    else $error("relay does not energise on alarm");
  a_relay_arrlvl: assert property (rsel_reg == 11'h057 |=>
                                   relay_coil == $past(arrival_reg && level_reg))
    else $error("combined arrival code mismatch");
  a_undefined: assert property (tsel_reg == 11'h004 || tsel_reg == 11'h3EC
                                |=> !transistor_terminal)
    else $error("undefined code drives terminal");
  a_default_pol: assert property (!$past(hresetn) |-> tsel_reg < POL_OFFSET
                                  && rsel_reg < POL_OFFSET)
    else $error("reset selection not normal polarity");
  a_dip_map: assert property (tsel_reg == 11'h006 ##1 tsel_reg == 11'h006
                              |=> transistor_terminal == $past(power_dip_restart))
    else $error("power dip restart code mismatch");
  a_irq_set: assert property (events[ST_RUN] && int_enable_reg[ST_RUN] |=> irq)
    else $error("interrupt missing after enabled event");

  c_run_start: cover property (!running_reg ##1 running_reg);
  c_relay_inverted: cover property (rsel_reg >= POL_OFFSET && !relay_coil);
  c_level_band: cover property (level_reg && output_freq < det_lvl_reg);
  c_set_clear: cover property (wr_clear && |events);

endmodule // dsm_output_mapper
`default_nettype wire

/* File: rtl/dsm_pkg.sv */
// constants, register map and selection codes for the drive status output mapper
// Summary of operation
// - per-terminal select code; plus 1000 inverts polarity
// - reset selections use normal active-high polarity
// - relay energises on alarm, inverted de-energises
// - transistor and relay terminals assigned independently
// - codes 0-3 map core signals, codes 5-7 map external inputs
// - codes 26 through 99 map listed signals
// - running above start, off below stop, braking
// - inverted running code indicates drive stopped
// - arrival when frequency difference within hysteresis
// - level detect with hysteresis below detection level
// - undervoltage below threshold or during trip
package dsm_pkg;

  localparam int SEL_W = 11;
  localparam int NUM_CODES = 100;
  localparam logic [SEL_W-1:0] POL_OFFSET = 11'h3E8;  // 1000
  localparam logic [SEL_W-1:0] CODE_MAX = 11'h44B;    // 1099

  // selection codes
  localparam int CODE_RUN = 0;
  localparam int CODE_ARRIVAL = 1;
  localparam int CODE_LEVEL = 2;
  localparam int CODE_UNDERVOLT = 3;
  localparam int CODE_OUT_LIMIT = 5;
  localparam int CODE_DIP_RESTART = 6;
  localparam int CODE_OL_WARN = 7;
  localparam int CODE_AUTO_RESET = 26;
  localparam int CODE_LIFETIME = 30;
  localparam int CODE_RUN_BRAKE = 35;
  localparam int CODE_OL_PREVENT = 36;
  localparam int CODE_CUR_DET = 37;
  localparam int CODE_CUR_DET2 = 38;
  localparam int CODE_LOW_CUR = 41;
  localparam int CODE_REG_ACTIVE = 43;
  localparam int CODE_REG_STOP = 44;
  localparam int CODE_MOTOR2 = 49;
  localparam int CODE_THERMISTOR = 56;
  localparam int CODE_BRAKE = 57;
  localparam int CODE_WIRE_BREAK = 59;
  localparam int CODE_MAINT = 84;
  localparam int CODE_ARR_LEVEL = 87;
  localparam int CODE_ALARM = 99;

  // register byte offsets
  localparam logic [7:0] OFS_TSEL = 8'h00;
  localparam logic [7:0] OFS_RSEL = 8'h04;
  localparam logic [7:0] OFS_ARR_HYST = 8'h08;
  localparam logic [7:0] OFS_DET_LVL = 8'h0C;
  localparam logic [7:0] OFS_DET_HYST = 8'h10;
  localparam logic [7:0] OFS_START_FREQ = 8'h14;
  localparam logic [7:0] OFS_STOP_FREQ = 8'h18;
  localparam logic [7:0] OFS_UV_LEVEL = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_INT_STATUS = 8'h24;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h28;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h2C;

  // status register bit positions, shared by the interrupt registers
  localparam int ST_RUN = 0;
  localparam int ST_ARRIVAL = 1;
  localparam int ST_LEVEL = 2;
  localparam int ST_UNDERVOLT = 3;
  localparam int ST_TRANSISTOR = 4;
  localparam int ST_RELAY = 5;
  localparam int NUM_EVENTS = 6;

  // reset values
  localparam logic [SEL_W-1:0] RST_TSEL = 11'h000;  // running, normal polarity
  localparam logic [SEL_W-1:0] RST_RSEL = 11'h063;  // any alarm, normal polarity
  localparam logic [31:0] RST_FREQ = 32'h0000_0000;
  localparam logic [NUM_EVENTS-1:0] RST_INT_ENABLE = 6'h00;

endpackage : dsm_pkg

/* File: rtl/dsm_term_drive.sv */
// one output terminal: selection code decode, polarity and output flop
`timescale 1ns/1ps
`default_nettype none
module dsm_term_drive
  import dsm_pkg::*;
(
  // clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // selection and status
  input  wire logic [dsm_pkg::SEL_W-1:0] sel_code,
  input  wire logic [dsm_pkg::NUM_CODES-1:0] status_vec,
  input  wire logic [dsm_pkg::NUM_CODES-1:0] defined_mask,
  // terminal
  output logic                          term_out
);
  logic [SEL_W-1:0] idx_wide;
  logic [6:0]       idx;
  logic             inverted;
  logic             valid;

  // split the code into signal index and polarity
  always_comb begin
    inverted = 1'b0;
    idx_wide = sel_code;
    if (sel_code >= POL_OFFSET) begin
      inverted = 1'b1;
      idx_wide = sel_code - POL_OFFSET;
    end
    idx   = idx_wide[6:0];
    valid = (sel_code <= CODE_MAX) && (idx_wide < SEL_W'(NUM_CODES)) && defined_mask[idx];
  end

  // undefined codes force the terminal off in either polarity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      term_out <= 1'b0;
    end else begin
      term_out <= valid ? (status_vec[idx] ^ inverted) : 1'b0;
    end
  end

endmodule // dsm_term_drive
`default_nettype wire

/* File: dv/dsm_ext_reader.sv */
// model of the outside equipment that reads the two output terminals
`timescale 1ns/1ps
`default_nettype none
module dsm_ext_reader #(
  parameter int MASK_CYC = 4  // stands in for the long settle time after power-on
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // terminals as wired
  input  wire logic t_in,
  input  wire logic no_in,
  input  wire logic nc_in,
  // qualified readings
  output logic      y_seen,
  output logic      r_seen
);
  int unsigned wait_cnt;
  // readings are ignored until the drive has settled after power-on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wait_cnt <= 0;
    else if (wait_cnt < MASK_CYC) wait_cnt <= wait_cnt + 1;
  end
  // drive stays powered here, so no supply interlock is needed
  // relay read only for slow signals, and only when both contacts agree
  assign y_seen = (wait_cnt >= MASK_CYC) & t_in;
  assign r_seen = (wait_cnt >= MASK_CYC) & no_in & ~nc_in;
endmodule // dsm_ext_reader
`default_nettype wire

/* File: dv/drive_status_output_mapper_tb_top.sv */
// self-checking bench for the drive status output mapper
`timescale 1ns/1ps
`default_nettype none
module drive_status_output_mapper_tb_top;
  localparam int CODES[17] = '{5, 6, 7, 26, 30, 36, 37, 38, 41, 43, 44, 49, 56, 57, 59, 84, 99};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [15:0] ofq = 16'h0000;
  logic [15:0] rfq = 16'h0000;
  logic [15:0] volt = 16'h0096;
  logic        brk = 1'b0;
  logic        trip = 1'b0;
  logic [16:0] ext = 17'h0_0000;
  logic        hreadyout, hresp, tterm, coil, no_c, nc_c, irq, y_seen, r_seen;
  logic [31:0] hrdata;
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;

  dsm_output_mapper dsm_output_mapper_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .output_freq(ofq),
    .reference_freq(rfq), .dc_bus_voltage(volt), .dc_braking(brk), .uv_trip_hold(trip),
    .output_limiting(ext[0]), .power_dip_restart(ext[1]), .motor_overload_warning(ext[2]),
    .auto_reset_active(ext[3]), .service_lifetime_alarm(ext[4]),
    .overload_prevention(ext[5]), .overcurrent_detect(ext[6]),
    .overcurrent_detect_second(ext[7]), .low_current_detect(ext[8]),
    .loop_regulator_active(ext[9]), .regulator_lowflow_stop(ext[10]),
    .second_motor_selected(ext[11]), .thermistor_overheat(ext[12]),
    .brake_command(ext[13]), .current_input_wire_break(ext[14]),
    .maintenance_timer(ext[15]), .any_alarm(ext[16]), .transistor_terminal(tterm),
    .relay_coil(coil), .relay_no_closed(no_c), .relay_nc_closed(nc_c), .irq(irq));

  dsm_ext_reader dsm_ext_reader_inst (.hclk(hclk), .hresetn(hresetn), .t_in(tterm),
    .no_in(no_c), .nc_in(nc_c), .y_seen(y_seen), .r_seen(r_seen));

  // free-running clock and a hang guard well above the expected run
  initial forever #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // register value compare and terminal level compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t level %b expected %b", $time, got, exp);
    end
  endtask

  // one single ahb-lite transfer; the wait only ends on hready or the hang guard
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(a, 1'b1, {16'h0000, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    chk(hrdata & {16'h0000, m}, {16'h0000, e});
    chkb(hresp, 1'b0);
  endtask
  // status flops then terminal flop need two edges; a third keeps sampling clear of them
  task automatic settle;
    repeat (3) @(posedge hclk);
  endtask

  task automatic scn_reset;
    rd(8'h00, 16'hFFFF, 16'h0000);
    rd(8'h04, 16'hFFFF, 16'h0063);
    rd(8'h30, 16'hFFFF, 16'h0000);
  endtask

  // core status: start 10, stop 5, arrival width 3, level 15 less 5, undervoltage 100
  task automatic scn_core;
    wr(8'h14, 16'h000A);
    wr(8'h18, 16'h0005);
    wr(8'h08, 16'h0003);
    wr(8'h0C, 16'h000F);
    wr(8'h10, 16'h0005);
    wr(8'h1C, 16'h0064);
    ofq <= 16'h0014;
    rfq <= 16'h0014;
    settle();
    rd(8'h20, 16'h000F, 16'h0007);
    ofq <= 16'h0018;
    settle();
    rd(8'h20, 16'h0002, 16'h0000);
    ofq <= 16'h000C;
    settle();
    rd(8'h20, 16'h0005, 16'h0005);
    ofq <= 16'h0008;
    settle();
    rd(8'h20, 16'h0005, 16'h0001);
    ofq <= 16'h0003;
    volt <= 16'h0032;
    settle();
    rd(8'h20, 16'h0009, 16'h0008);
    volt <= 16'h0096;
    trip <= 1'b1;
    settle();
    rd(8'h20, 16'h0008, 16'h0008);
    trip <= 1'b0;
  endtask

  // polarity, relay contacts, braking and undefined codes
  task automatic scn_term;
    wr(8'h00, 16'h03E8);
    settle();
    chkb(y_seen, 1'b1);
    ext[16] <= 1'b1;
    ofq <= 16'h0014;
    settle();
    chkb(y_seen, 1'b0);
    chkb(r_seen, 1'b1);
    wr(8'h04, 16'h044B);
    settle();
    chkb(r_seen, 1'b0);
    wr(8'h04, 16'h03EC);
    wr(8'h00, 16'h03EC);
    settle();
    chkb(r_seen, 1'b0);
    chkb(y_seen, 1'b0);
    brk <= 1'b1;
    wr(8'h00, 16'h0023);
    settle();
    chkb(y_seen, 1'b1);
    rd(8'h20, 16'h0001, 16'h0000);
    brk <= 1'b0;
    wr(8'h00, 16'h0057);
    wr(8'h04, 16'h0057);
    settle();
    chkb(y_seen, 1'b1);
    chkb(r_seen, 1'b1);
    rd(8'h20, 16'h0030, 16'h0030);
    wr(8'h00, 16'h0001);
    settle();
    chkb(y_seen, 1'b1);
    wr(8'h00, 16'h03EA);
    settle();
    chkb(y_seen, 1'b0);
    wr(8'h00, 16'h03EB);
    settle();
    chkb(y_seen, 1'b1);
  endtask

  // every externally fed code, on then off
  task automatic scn_codes;
    for (int i = 0; i < 17; i++) begin
      ext <= 17'h0_0001 << i;
      wr(8'h00, 16'(CODES[i]));
      settle();
      chkb(y_seen, 1'b1);
      ext <= 17'h0_0000;
      settle();
      chkb(y_seen, 1'b0);
    end
  endtask

  // running event: raised, masked, unmasked, cleared
  task automatic scn_irq;
    ofq <= 16'h0003;
    wr(8'h2C, 16'h0001);
    settle();
    wr(8'h28, 16'h003F);
    settle();
    chkb(irq, 1'b0);
    ofq <= 16'h0014;
    settle();
    chkb(irq, 1'b1);
    rd(8'h24, 16'h0001, 16'h0001);
    wr(8'h2C, 16'h0000);
    settle();
    chkb(irq, 1'b0);
    wr(8'h2C, 16'h0001);
    wr(8'h28, 16'h0001);
    settle();
    chkb(irq, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    scn_reset();
    scn_core();
    scn_term();
    scn_codes();
    scn_irq();
    complete_run();
  end
endmodule // drive_status_output_mapper_tb_top
`default_nettype wire
